//--- hdl/afi_pkg.sv
// constants and types shared by the converter serial frame interface
package afi_pkg;

  localparam int CTRL_W = 12;
  localparam int WORD_W = 16;
  localparam int CODE_W = 12;
  localparam int TAG_W = 2;
  localparam int RES_W = TAG_W + CODE_W;
  localparam int FIFO_DEPTH = 16;

  // falling serial clock counts inside a frame
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] CNT_CTRL_LAST = 5'h0c;
  localparam logic [4:0] CNT_TRACK = 5'h0e;
  localparam logic [4:0] CNT_LAST_BIT = 5'h0f;
  localparam logic [4:0] CNT_FRAME = 5'h10;

  // control word layout, write flag is the first bit shifted in
  localparam int CTRL_WRITE_BIT = 11;
  localparam int CTRL_TAG_HI_BIT = 8;
  localparam int CTRL_TAG_LO_BIT = 7;
  localparam int CTRL_PM_HI_BIT = 6;
  localparam int CTRL_PM_LO_BIT = 5;

  // power mode encodings {power_mode_high, power_mode_low}
  localparam logic [1:0] PM_NORMAL = 2'h3;
  localparam logic [1:0] PM_FULL_DOWN = 2'h2;
  localparam logic [1:0] PM_AUTO_DOWN = 2'h1;

  // stored control bits below the write flag; normal mode after reset
  localparam logic [CTRL_W-2:0] CTRL_RESET = 11'h060;

  // two leading zero bits ahead of the channel tag
  localparam logic [1:0] LEAD_ZEROS = 2'h0;

  typedef enum logic [1:0] {
    AFI_IDLE,
    AFI_FRAME,
    AFI_TAIL
  } afi_state_t;

endpackage

//--- hdl/afi_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module afi_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic d_async,
  output logic q
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic q_ff;

  // first stage feeds only the second one
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_ff <= INIT;
      s2_ff <= INIT;
      s3_ff <= INIT;
    end else begin
      s1_ff <= d_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q_ff <= INIT;
    end else if (s2_ff == s3_ff) begin
      q_ff <= s3_ff;
    end
  end

  assign q = q_ff;

endmodule

//--- hdl/afi_fifo.sv
// result fifo with registered read data and registered flags
`timescale 1ns/10ps
module afi_fifo #(
  parameter int W = 14,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] CNT_ONE_F = (AW+1)'(1);
  localparam logic [AW-1:0] PTR_ONE = AW'(1);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic [AW:0] nxt_count;
  logic in_ready_ff;
  logic out_valid_ff;
  logic [W-1:0] out_data_ff;
  logic push;
  logic pop;

  assign push = in_valid && in_ready_ff;
  assign pop = out_ready && out_valid_ff;

  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + CNT_ONE_F;
    end else if (pop && !push) begin
      nxt_count = count_ff - CNT_ONE_F;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      in_ready_ff <= 1'b0;
      out_valid_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + PTR_ONE;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + PTR_ONE;
      end
      count_ff <= nxt_count;
      in_ready_ff <= (nxt_count != FULL_CNT);
      out_valid_ff <= (nxt_count != '0);
    end
  end

  // read data lands one cycle after the pop
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      out_data_ff <= '0;
    end else if (pop) begin
      out_data_ff <= mem_ff[rd_ptr_ff];
    end
  end

  assign in_ready = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data = out_data_ff;

endmodule

//--- hdl/afi_frame.sv
// serial frame and conversion timing logic of a four-channel converter
`timescale 1ns/10ps
// Functional notes
// - chip select fall: sample input, hold, drive output, start conversion
// - conversion and transfer take exactly 16 serial clocks, host supplies all
// - track mode resumes on the fourteenth falling serial clock edge
// - complete frame releases output on the sixteenth falling edge
// - early chip select rise aborts, releases output, keeps control register
// - word is two zeros, two tag bits high first, then result bits
// - chip select fall presents first bit, each falling edge the next
// - last bit driven on fifteenth fall, valid at the sixteenth
// - 12-bit control word on first 12 falls, loaded only if write flag set
// - 8-bit variant pads with four trailing zeros
// - 10-bit variant pads with two trailing zeros
// - 12-bit variant fills the word without padding
// - automatic shutdown powers the device down from each full-frame end to the next chip select fall
// - power mode 11 normal, 10 full shutdown, 01 automatic shutdown
// - write flag zero leaves all control contents unchanged
module afi_frame
  import afi_pkg::*;
#(
  parameter int RES_BITS = 12
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic dout_oe_n,
  input wire logic res_valid,
  output logic res_ready,
  input wire logic [RES_W-1:0] res_data,
  output logic sample_strobe,
  output logic [TAG_W-1:0] sample_chan,
  output logic track_mode,
  output logic powered_down,
  output logic conv_busy,
  output logic frame_abort,
  output logic [CTRL_W-2:0] ctrl_word
);

  // result bits below the kept ones read as zero trailing padding
  localparam logic [CODE_W-1:0] CODE_MASK = ~(CODE_W'((1 << (CODE_W - RES_BITS)) - 1));

  logic cs_n_s;
  logic sclk_s;
  logic din_s;
  logic cs_n_d_ff;
  logic sclk_d_ff;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  afi_state_t state_ff;
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic [WORD_W-1:0] word_ff;
  logic load_pend_ff;
  logic took_res_ff;
  logic [CTRL_W-1:0] shift_ff;
  logic [CTRL_W-2:0] ctrl_ff;
  logic [1:0] pm_new;
  logic dout_ff;
  logic dout_oe_n_ff;
  logic sample_ff;
  logic [TAG_W-1:0] chan_ff;
  logic track_ff;
  logic down_ff;
  logic busy_ff;
  logic abort_ff;
  logic fifo_valid;
  logic [RES_W-1:0] fifo_data;
  logic fifo_pop;
  logic edge_in_frame;

  afi_sync #(.INIT(1'b1)) u_sync_cs (
    .clk_sys(clk_sys),
    .reset(reset),
    .d_async(cs_n),
    .q(cs_n_s)
  );

  afi_sync #(.INIT(1'b0)) u_sync_sclk (
    .clk_sys(clk_sys),
    .reset(reset),
    .d_async(sclk),
    .q(sclk_s)
  );

  afi_sync #(.INIT(1'b0)) u_sync_din (
    .clk_sys(clk_sys),
    .reset(reset),
    .d_async(din),
    .q(din_s)
  );

  // results wait here; frames drain one each, so the core sees back-pressure
  afi_fifo #(.W(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(res_valid),
    .in_ready(res_ready),
    .in_data(res_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cs_n_d_ff <= 1'b1;
      sclk_d_ff <= 1'b0;
    end else begin
      cs_n_d_ff <= cs_n_s;
      sclk_d_ff <= sclk_s;
    end
  end

  assign cs_fall = cs_n_d_ff && !cs_n_s;
  assign cs_rise = !cs_n_d_ff && cs_n_s;
  assign sclk_fall = sclk_d_ff && !sclk_s;
  assign edge_in_frame = sclk_fall && !cs_n_s && (state_ff == AFI_FRAME);
  assign nxt_cnt = cnt_ff + CNT_ONE;
  assign fifo_pop = cs_fall && fifo_valid;
  assign pm_new = {shift_ff[CTRL_PM_HI_BIT], shift_ff[CTRL_PM_LO_BIT]};

  // frame sequencing; edges past the sixteenth are ignored
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_ff <= AFI_IDLE;
      cnt_ff <= CNT_ZERO;
    end else begin
      unique case (state_ff)
        AFI_IDLE: begin
          if (cs_fall) begin
            state_ff <= AFI_FRAME;
            cnt_ff <= CNT_ZERO;
          end
        end
        AFI_FRAME: begin
          if (cs_rise) begin
            state_ff <= AFI_IDLE;
          end else if (edge_in_frame) begin
            cnt_ff <= nxt_cnt;
            if (nxt_cnt == CNT_FRAME) begin
              state_ff <= AFI_TAIL;
            end
          end
        end
        AFI_TAIL: begin
          if (cs_rise) begin
            state_ff <= AFI_IDLE;
          end
        end
      endcase
    end
  end

  // output word: leading zeros, tag, result, zero padding
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      word_ff <= '0;
      load_pend_ff <= 1'b0;
      took_res_ff <= 1'b0;
    end else begin
      load_pend_ff <= cs_fall;
      if (cs_fall) begin
        took_res_ff <= fifo_valid;
      end
      if (load_pend_ff) begin
        if (took_res_ff) begin
          word_ff <= {LEAD_ZEROS, fifo_data[RES_W-1 -: TAG_W],
                      fifo_data[CODE_W-1:0] & CODE_MASK};
        end else begin
          word_ff <= {LEAD_ZEROS, chan_ff, {CODE_W{1'b0}}};
        end
      end
    end
  end

  // serial output; oe_n low while driving
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dout_ff <= 1'b0;
      dout_oe_n_ff <= 1'b1;
    end else if (cs_fall && state_ff == AFI_IDLE) begin
      dout_ff <= LEAD_ZEROS[1];
      dout_oe_n_ff <= 1'b0;
    end else if (cs_rise) begin
      dout_oe_n_ff <= 1'b1;
    end else if (edge_in_frame) begin
      if (nxt_cnt == CNT_FRAME) begin
        dout_oe_n_ff <= 1'b1;
      end else begin
        dout_ff <= word_ff[4'(CNT_LAST_BIT - nxt_cnt)];
      end
    end
  end

  // control word capture on the first twelve falls, commit at full-frame end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      shift_ff <= '0;
      ctrl_ff <= CTRL_RESET;
    end else begin
      if (edge_in_frame && nxt_cnt <= CNT_CTRL_LAST) begin
        shift_ff <= {shift_ff[CTRL_W-2:0], din_s};
      end
      if (cs_rise && state_ff == AFI_TAIL && shift_ff[CTRL_WRITE_BIT]) begin
        ctrl_ff <= shift_ff[CTRL_W-2:0];
      end
    end
  end

  // sampling, track and hold, busy and abort indication
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sample_ff <= 1'b0;
      chan_ff <= '0;
      track_ff <= 1'b1;
      busy_ff <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      sample_ff <= cs_fall && state_ff == AFI_IDLE;
      abort_ff <= cs_rise && state_ff == AFI_FRAME;
      if (cs_fall && state_ff == AFI_IDLE) begin
        chan_ff <= {ctrl_ff[CTRL_TAG_HI_BIT], ctrl_ff[CTRL_TAG_LO_BIT]};
        track_ff <= 1'b0;
        busy_ff <= 1'b1;
      end else if (cs_rise && state_ff == AFI_FRAME) begin
        track_ff <= 1'b1;
        busy_ff <= 1'b0;
      end else if (edge_in_frame && nxt_cnt == CNT_TRACK) begin
        track_ff <= 1'b1;
      end else if (edge_in_frame && nxt_cnt == CNT_FRAME) begin
        busy_ff <= 1'b0;
      end else if (cs_rise && state_ff == AFI_TAIL &&
                   (shift_ff[CTRL_WRITE_BIT] ? pm_new :
                    ctrl_ff[CTRL_PM_HI_BIT -: $bits(pm_new)]) != PM_NORMAL) begin
        track_ff <= 1'b0; // shutdown holds the track and hold, whatever mode it came from
      end
    end
  end

  // power state follows the mode committed at the end of each full frame
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      down_ff <= 1'b0;
    end else if (cs_rise && state_ff == AFI_TAIL) begin
      if (shift_ff[CTRL_WRITE_BIT]) begin
        down_ff <= (pm_new != PM_NORMAL);
      end else begin
        down_ff <= {ctrl_ff[CTRL_PM_HI_BIT], ctrl_ff[CTRL_PM_LO_BIT]} != PM_NORMAL;
      end
    end else if (cs_fall &&
                 {ctrl_ff[CTRL_PM_HI_BIT], ctrl_ff[CTRL_PM_LO_BIT]} == PM_AUTO_DOWN) begin
      down_ff <= 1'b0; // wakes at chip select fall, down again only at the next full-frame end
    end
  end

  assign dout = dout_ff;
  assign dout_oe_n = dout_oe_n_ff;
  assign sample_strobe = sample_ff;
  assign sample_chan = chan_ff;
  assign track_mode = track_ff;
  assign powered_down = down_ff;
  assign conv_busy = busy_ff;
  assign frame_abort = abort_ff;
  assign ctrl_word = ctrl_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_start;
    cs_fall && state_ff == AFI_IDLE |=> !dout_oe_n_ff && !track_ff && sample_ff && !dout_ff;
  endproperty
  a_start: assert property (p_start) else $error("frame start not taken");

  property p_track;
    edge_in_frame && nxt_cnt == CNT_TRACK && !cs_rise |=> track_ff;
  endproperty
  a_track: assert property (p_track) else $error("track not resumed at 14");

  property p_release;
    edge_in_frame && nxt_cnt == CNT_FRAME && !cs_rise |=> dout_oe_n_ff && state_ff == AFI_TAIL;
  endproperty
  a_release: assert property (p_release) else $error("output not released at 16");

  property p_abort;
    cs_rise && state_ff == AFI_FRAME |=> dout_oe_n_ff && frame_abort && $stable(ctrl_ff);
  endproperty
  a_abort: assert property (p_abort) else $error("abort mishandled");

  property p_last_bit;
    edge_in_frame && nxt_cnt == CNT_LAST_BIT && !cs_rise |=> dout_ff == word_ff[0];
  endproperty
  a_last_bit: assert property (p_last_bit) else $error("last bit wrong");

  property p_shift;
    edge_in_frame && nxt_cnt < CNT_FRAME && !cs_rise |=> dout_ff == word_ff[4'(CNT_LAST_BIT - cnt_ff)];
  endproperty
  a_shift: assert property (p_shift) else $error("output bit out of order");

  property p_pad;
    state_ff == AFI_FRAME && (cnt_ff <= CNT_ONE ||
      int'(cnt_ff) > int'(CNT_LAST_BIT) - CODE_W + RES_BITS) |-> !dout_ff;
  endproperty
  a_pad: assert property (p_pad) else $error("padding or leading zeros wrong");

  property p_commit;
    cs_rise && state_ff == AFI_TAIL && shift_ff[CTRL_WRITE_BIT]
      |=> {1'b1, ctrl_ff} == $past(shift_ff);
  endproperty
  a_commit: assert property (p_commit) else $error("control word not committed");

  property p_no_write;
    cs_rise && !shift_ff[CTRL_WRITE_BIT] |=> $stable(ctrl_ff);
  endproperty
  a_no_write: assert property (p_no_write) else $error("control changed without write");

  property p_auto;
    cs_rise && state_ff == AFI_TAIL && shift_ff[CTRL_WRITE_BIT] && pm_new == PM_AUTO_DOWN
      |=> powered_down ##1 (powered_down && !track_mode);
  endproperty
  a_auto: assert property (p_auto) else $error("auto shutdown not entered");

  c_full: cover property (edge_in_frame && nxt_cnt == CNT_FRAME);
  c_abort: cover property (cs_rise && state_ff == AFI_FRAME);
  c_write: cover property (cs_rise && state_ff == AFI_TAIL && shift_ff[CTRL_WRITE_BIT]);
  c_full_down: cover property (cs_rise && state_ff == AFI_TAIL && pm_new == PM_FULL_DOWN);

endmodule

//--- sim/afi_host.sv
// serial port host model: frames chip select, makes the serial clock, reads words
`timescale 1ns/10ps
module afi_host (
  input wire logic clk_sys,
  input wire logic [2:0] dout,
  input wire logic [2:0] dout_oe_n,
  output logic cs_n,
  output logic sclk,
  output logic din,
  output logic [2:0][15:0] word,
  output logic word_done,
  output int falls
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
    word = '0;
    word_done = 1'b0;
    falls = 0;
  end

  task automatic half();
    repeat (4) @(negedge clk_sys);
  endtask

  // frame length follows n, so chip select falls are evenly spaced only between frames of equal n
  task automatic frame(input logic [11:0] cw, input int n);
    @(negedge clk_sys);
    cs_n <= 1'b0;
    falls <= 0;
    din <= cw[11];
    half();
    half();
    for (int k = 1; k <= n; k++) begin // all 16 clocks unless aborting
      sclk <= 1'b0;
      falls <= k;
      // a released line reads as unknown, so it can never match
      for (int v = 0; v < 3; v++)
        word[v][16-k] <= dout_oe_n[v] ? 1'bx : dout[v];
      half();
      sclk <= 1'b1;
      din <= (k < 12) ? cw[11-k] : ~din; // control word msb first
      half();
    end
    cs_n <= 1'b1;
    din <= ~din;
    word_done <= (n == 16);
    @(negedge clk_sys);
    word_done <= 1'b0;
    repeat (8) @(negedge clk_sys); // idle gap before the next frame
  endtask
endmodule

//--- sim/test_adc_serial_frame_interface.sv
// self-checking bench for the converter serial frame interface
`timescale 1ns/10ps
module test_adc_serial_frame_interface
  import afi_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic res_valid = 1'b0;
  logic watch = 1'b1;
  logic [RES_W-1:0] res_data = '0;
  logic cs_n, sclk, din, word_done;
  logic [2:0] dout, dout_oe_n, res_ready, strobe, track, pdown, busy, abort;
  logic [2:0][TAG_W-1:0] chan;
  logic [2:0][CTRL_W-2:0] ctrl;
  logic [2:0][WORD_W-1:0] word;
  logic [WORD_W-1:0] got_e;
  logic [RES_W-1:0] fifo_m[$];
  logic [WORD_W-1:0] exp_q[$];
  logic [CTRL_W-2:0] ctrl_m = CTRL_RESET;
  int falls, n_strobe = 0, n_abort = 0, n_frame = 0;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;

  always #10 clk_sys = ~clk_sys;

  // one instance per variant, all fed the same frames
  for (genvar g = 0; g < 3; g++) begin : g_var
    afi_frame #(.RES_BITS(8 + 2 * g)) dut (
      .clk_sys(clk_sys), .reset(reset), .cs_n(cs_n), .sclk(sclk), .din(din),
      .dout(dout[g]), .dout_oe_n(dout_oe_n[g]), .res_valid(res_valid),
      .res_ready(res_ready[g]), .res_data(res_data), .sample_strobe(strobe[g]),
      .sample_chan(chan[g]), .track_mode(track[g]), .powered_down(pdown[g]),
      .conv_busy(busy[g]), .frame_abort(abort[g]), .ctrl_word(ctrl[g]));
  end

  afi_host host (.clk_sys(clk_sys), .dout(dout), .dout_oe_n(dout_oe_n), .cs_n(cs_n),
    .sclk(sclk), .din(din), .word(word), .word_done(word_done), .falls(falls));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // an empty fifo yields code zero with the stored channel tag
  task automatic run(input logic [11:0] cw, input int n);
    logic [WORD_W-1:0] x;
    x = {LEAD_ZEROS, ctrl_m[8:7], 12'h000};
    if (fifo_m.size() > 0)
      x = {LEAD_ZEROS, fifo_m.pop_front()};
    if (n == 16)
      exp_q.push_back(x);
    n_frame++;
    host.frame(cw, n);
    check({14'h0, chan[0]}, {14'h0, ctrl_m[8:7]});
    if (n == 16 && cw[11])
      ctrl_m = cw[10:0];
    x = {1'b0, ctrl_m, ctrl_m[6:5] != PM_NORMAL, 3'h7};
    check({1'b0, ctrl[0], pdown[0], dout_oe_n}, x);
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (strobe[0])
      n_strobe <= n_strobe + 1;
    if (abort[0])
      n_abort <= n_abort + 1;
    if (word_done && exp_q.size() > 0) begin
      got_e = exp_q.pop_front();
      // narrower variants zero the low code bits
      for (int g = 0; g < 3; g++)
        check(word[g], got_e & ~((16'h1 << (4 - 2 * g)) - 16'h1));
    end
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  // fall 14 is skipped: track may change within the sync latency there
  always @(negedge clk_sys)
    if (watch && !cs_n && falls > 0 && falls < 16 && falls != 14)
      check({7'h0, track, busy, dout_oe_n}, {7'h0, {3{falls == 15}}, 6'h38});

  initial begin
    logic [RES_W-1:0] d;
    void'($urandom(32'hd7c677d5));
    d = '0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    reset <= 1'b0;
    repeat (8) @(negedge clk_sys);
    check({1'b0, ctrl[0], pdown[0], dout_oe_n}, {1'b0, CTRL_RESET, 1'b0, 3'h7});
    check({13'h0, track & res_ready}, 16'h7);
    $display("reset test done");
    // fill with no frames running; held offer stays refused once full
    repeat (20) begin
      @(negedge clk_sys);
      if (res_ready[0]) begin
        d = RES_W'($urandom);
        fifo_m.push_back(d);
        res_data <= d;
      end
      res_valid <= 1'b1;
    end
    res_valid <= 1'b0;
    check({15'h0, res_ready[0]}, 16'h0);
    check(16'(fifo_m.size()), 16'(FIFO_DEPTH));
    $display("fifo fill test done");
    for (int i = 0; i < 19; i++)
      run(12'($urandom) | 12'h060, (i == 4) ? 15 : (i == 9) ? 3 : 16);
    $display("frame test done");
    run(12'h820, 16);
    run(12'h000, 16);
    run(12'h840, 16);
    watch = 1'b0;
    run(12'h860, 16);
    watch = 1'b1;
    check(16'(n_strobe), 16'(n_frame));
    check(16'(n_abort), 16'h2);
    $display("mode test done");
    wrap_up();
  end
endmodule
